//--- core/sfx_consts.vh
`ifndef SFX_CONSTS_VH
`define SFX_CONSTS_VH

// ----------------------------------------
// instruction word layout
// ----------------------------------------
`define SFX_INSTR_W          16
`define SFX_DATA_W           32
`define SFX_ADDR_W           5
`define SFX_DELAY_MSB        12
`define SFX_DELAY_LSB        8
// no-operation encoding (mov y, y) used to clear a stalled forced word
`define SFX_NOP_WORD         16'hA042
`define SFX_INSTR_RESET      16'h0000
`define SFX_PC_RESET         5'h00

// ----------------------------------------
// latch source codes
// ----------------------------------------
`define SFX_SRC_NONE         2'h0
`define SFX_SRC_EXEC         2'h1
`define SFX_SRC_FORCED       2'h2

`endif

//--- core/sfx_latch.v
`timescale 1ns/1ps
`include "sfx_consts.vh"

// holds the single pending instruction shared by all injection paths
module sfx_latch (
    // clock and reset
    input  wire                     clk_in,
    input  wire                     rst_n_in,
    // load and clear
    input  wire                     load_in,
    input  wire [`SFX_INSTR_W-1:0]  load_word_in,
    input  wire [1:0]               load_src_in,
    input  wire                     clear_in,
    // stored word
    output reg  [`SFX_INSTR_W-1:0]  word_out,
    output reg  [1:0]               src_out
);

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_out <= `SFX_INSTR_RESET;
            src_out  <= `SFX_SRC_NONE;
        end else if (load_in) begin
            // load beats clear: a new stall or exec word must not be lost
            word_out <= load_word_in;
            src_out  <= load_src_in;
        end else if (clear_in) begin
            src_out  <= `SFX_SRC_NONE;
        end
    end

endmodule // sfx_latch

//--- core/sfx_exec.v
// What this block does
// - instructions come from memory, move-to-exec, shift-out-to-exec and the forced register.
// - a software-written forced word executes at once instead of the fetched word.
// - forced words hold the program counter; resume after unless it jumped.
// - delay field of a forced word is ignored; no delay cycles follow.
// - a forced word executes on write without waiting for the clock divider enable; its latched retry waits for it.
// - a stalling forced word is latched and retried; stalled flag reads set meanwhile.
// - restart or a forced no-operation clears the latched word and stalled flag.
// - shift-out-to-exec takes one cycle; delivered word runs next execution cycle.
// - shift-out data goes to the latch; next cycle runs it, holding the counter.
// - at most one shift-out executes per cycle, even if the delivered word shifts.
// - a stalled forced word uses the shared latch, replacing anything pending.
// - a 32-bit shifted word executes its low 16 bits.
`timescale 1ns/1ps
`include "sfx_consts.vh"

module sfx_exec (
    // clock and reset
    input  wire                     clk_in,
    input  wire                     rst_n_in,
    // machine control
    input  wire                     enable_in,
    input  wire                     restart_in,
    input  wire                     divider_tick_in,
    // forced instruction register write
    input  wire                     forced_wr_in,
    input  wire [`SFX_INSTR_W-1:0]  forced_wdata_in,
    // instruction memory fetch
    input  wire [`SFX_INSTR_W-1:0]  imem_word_in,
    // feedback from the execute stage
    input  wire                     stall_in,
    input  wire                     jump_in,
    input  wire [`SFX_ADDR_W-1:0]   jump_target_in,
    input  wire                     wrap_in,
    input  wire [`SFX_ADDR_W-1:0]   wrap_target_in,
    input  wire                     out_exec_in,
    input  wire                     mov_exec_in,
    input  wire [`SFX_DATA_W-1:0]   exec_data_in,
    input  wire [`SFX_DELAY_MSB-`SFX_DELAY_LSB:0] delay_in,
    // to the execute stage
    output wire                     issue_out,
    output wire [`SFX_INSTR_W-1:0]  issue_word_out,
    output wire                     issue_forced_out,
    output wire                     out_allowed_out,
    output reg  [`SFX_ADDR_W-1:0]   pc_out,
    output wire                     execute_stalled_flag_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam [2:0] ST_FETCH = 3'b001;
    localparam [2:0] ST_LATCH = 3'b010;
    localparam [2:0] ST_DELAY = 3'b100;

    reg  [2:0]                  state_reg;
    reg  [2:0]                  state_next;
    reg  [4:0]                  delay_reg;
    reg  [4:0]                  delay_next;
    reg  [`SFX_ADDR_W-1:0]      pc_next;
    reg                         last_out_reg;
    wire [`SFX_INSTR_W-1:0]     latch_word;
    wire [1:0]                  latch_src;
    wire                        latch_load;
    wire [`SFX_INSTR_W-1:0]     latch_load_word;
    wire [1:0]                  latch_load_src;
    wire                        latch_clear;
    wire                        forced_nop;
    wire                        from_latch;
    wire                        tick;
    wire                        forced_stall;
    wire                        exec_load;
    wire                        latched_forced;
    wire                        latch_load_ok;

    // ----------------------------------------
    // instruction source selection
    // ----------------------------------------
    assign forced_nop  = forced_wr_in && (forced_wdata_in == `SFX_NOP_WORD);
    assign from_latch  = (state_reg == ST_LATCH);
    assign tick        = enable_in && divider_tick_in;
    // forced words bypass divider tick and delay countdown
    assign issue_forced_out = enable_in && forced_wr_in && !forced_nop;
    assign issue_out   = issue_forced_out ||
                         (tick && (state_reg != ST_DELAY));
    assign issue_word_out = issue_forced_out ? forced_wdata_in :
                            (from_latch ? latch_word : imem_word_in);
    // a word delivered by shift-out may not shift out again this cycle
    assign out_allowed_out = !(from_latch && last_out_reg && !issue_forced_out);

    assign forced_stall = issue_forced_out && stall_in;
    assign exec_load    = issue_out && !stall_in && (out_exec_in || mov_exec_in);

    // stalled forced word takes the latch, overwriting a pending exec word
    assign latch_load      = forced_stall || exec_load;
    assign latch_load_word = forced_stall ? forced_wdata_in :
                             exec_data_in[`SFX_INSTR_W-1:0];
    assign latch_load_src  = forced_stall ? `SFX_SRC_FORCED : `SFX_SRC_EXEC;
    // restart or forced no-operation drops whatever is pending
    assign latch_clear     = restart_in || forced_nop ||
                             (from_latch && issue_out && !stall_in && !issue_forced_out);
    // restart and a forced no-operation must win over any load
    assign latch_load_ok   = latch_load && !restart_in && !forced_nop;

    // ----------------------------------------
    // stalled flag
    // ----------------------------------------
    // flag is just the latch owner, so it can never disagree with the latch
    assign execute_stalled_flag_out = (latch_src == `SFX_SRC_FORCED);
    // a retried forced word sits in the latch but still skips its delay
    assign latched_forced  = from_latch && (latch_src == `SFX_SRC_FORCED);

    // ----------------------------------------
    // shared instruction latch
    // ----------------------------------------
    sfx_latch u_latch (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .load_in      (latch_load_ok),
        .load_word_in (latch_load_word),
        .load_src_in  (latch_load_src),
        .clear_in     (latch_clear),
        .word_out     (latch_word),
        .src_out      (latch_src)
    );

    // ----------------------------------------
    // program counter and sequencing
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        delay_next = delay_reg;
        pc_next    = pc_out;
        if (restart_in) begin
            state_next = ST_FETCH;
            delay_next = 5'h00;
        end else if (issue_forced_out) begin
            // pc holds unless the forced word jumps; no delay applied
            if (!stall_in && jump_in) begin
                pc_next = jump_target_in;
            end
            if (stall_in || exec_load) begin
                state_next = ST_LATCH;
            end else if (latched_forced) begin
                state_next = ST_FETCH;
            end
        end else if (forced_nop) begin
            // a running delay is the program's own, so it is kept, but it does not count down this cycle
            if (state_reg == ST_DELAY) begin
                state_next = ST_DELAY;
            end else begin
                state_next = ST_FETCH;
            end
        end else if (tick) begin
            case (state_reg)
                ST_DELAY: begin
                    delay_next = delay_reg - 5'h01;
                    if (delay_reg == 5'h01) begin
                        state_next = ST_FETCH;
                    end
                end
                default: begin
                    // a stalled word repeats on the next tick, pc untouched
                    if (!stall_in) begin
                        if (jump_in) begin
                            pc_next = jump_target_in;
                        end else if (!from_latch) begin
                            if (wrap_in) begin
                                pc_next = wrap_target_in;
                            end else begin
                                pc_next = pc_out + 5'h01;
                            end
                        end
                        if (exec_load) begin
                            state_next = ST_LATCH;
                        end else if ((delay_in != 5'h00) && !latched_forced) begin
                            state_next = ST_DELAY;
                            delay_next = delay_in;
                        end else begin
                            state_next = ST_FETCH;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_FETCH;
            delay_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            delay_reg <= delay_next;
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_out <= `SFX_PC_RESET;
        end else begin
            pc_out <= pc_next;
        end
    end

    // ----------------------------------------
    // shift-out memory
    // ----------------------------------------
    // remember that the pending word came via a shift-out
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_out_reg <= 1'b0;
        end else if (exec_load) begin
            last_out_reg <= out_exec_in;
        end
    end

endmodule // sfx_exec

//--- tb/sfx_exec_monitor.sv
`timescale 1ns/1ps
`include "sfx_consts.vh"
module sfx_exec_monitor (
    // clock and reset
    input wire        clk_in,
    input wire        rst_n_in,
    // stimulus side
    input wire        enable_in,
    input wire        restart_in,
    input wire        divider_tick_in,
    input wire        forced_wr_in,
    input wire [15:0] forced_wdata_in,
    input wire        stall_in,
    input wire        jump_in,
    input wire        out_exec_in,
    input wire [31:0] exec_data_in,
    // design side
    input wire        issue_out,
    input wire [15:0] issue_word_out,
    input wire        issue_forced_out,
    input wire        out_allowed_out,
    input wire [4:0]  pc_out,
    input wire        execute_stalled_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire wr_ok = forced_wr_in && enable_in;
    sequence s_load; issue_out && out_exec_in && !stall_in && !restart_in; endsequence
    sequence s_run; divider_tick_in && !forced_wr_in && !restart_in; endsequence
    a_forced_runs_now: assert property (wr_ok && forced_wdata_in != `SFX_NOP_WORD |->
        issue_out && issue_forced_out && issue_word_out == forced_wdata_in) else $error("forced word late");
    a_forced_pc_hold: assert property (issue_forced_out && !jump_in && !restart_in |=> $stable(pc_out))
        else $error("pc moved on forced word");
    a_stall_sets_flag: assert property (issue_forced_out && stall_in && !restart_in |=>
        execute_stalled_flag_out) else $error("stalled flag not set");
    a_stall_flag_clear: assert property (restart_in || (wr_ok && forced_wdata_in == `SFX_NOP_WORD) |=>
        !execute_stalled_flag_out) else $error("stalled flag not cleared");
    a_exec_word_next: assert property (s_load ##1 s_run |-> issue_out && !issue_forced_out
        && issue_word_out == $past(exec_data_in[15:0])) else $error("latched word wrong");
    a_exec_pc_hold: assert property (s_load ##1 (divider_tick_in && !forced_wr_in && !restart_in && !jump_in)
        |=> $stable(pc_out))
        else $error("pc moved on latched word");
    a_one_shift_out: assert property (s_load ##1 s_run |-> !out_allowed_out)
        else $error("second shift-out allowed");
    a_no_forced_delay: assert property (issue_forced_out && !stall_in ##1
        (s_run && enable_in && !execute_stalled_flag_out) |-> issue_out) else $error("delay after forced word");
endmodule // sfx_exec_monitor
bind sfx_exec sfx_exec_monitor i_mon (.*);

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "sfx_consts.vh"
module testbench;
    logic        clk_in, rst_n_in, enable_in, restart_in, divider_tick_in, forced_wr_in;
    logic        stall_in, jump_in, wrap_in, out_exec_in, mov_exec_in;
    logic [15:0] forced_wdata_in, imem_word_in, issue_word_out;
    logic [4:0]  jump_target_in, wrap_target_in, delay_in, pc_out, pc_seen;
    logic [31:0] exec_data_in;
    wire         issue_out, issue_forced_out, out_allowed_out, execute_stalled_flag_out;
    int          errors = 0;
    int          samples_checked = 0;
    sfx_exec i_dut (.*);
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task step;
        @(posedge clk_in);
        #10;
    endtask
    task chk(input logic ok, input string what);
        samples_checked++;
        if (!ok) begin
            errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task stop_test;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // forced word: refused when off, immediate, pc held, no delay, jump
    task t_forced;
        {forced_wr_in, enable_in, delay_in, forced_wdata_in} = {1'b1, 1'b0, 5'h1F, 16'h0123};
        pc_seen = pc_out;
        #1 chk(issue_out === 1'b0, "taken while disabled");
        enable_in = 1'b1;
        #1 chk(issue_forced_out === 1'b1 && issue_word_out === 16'h0123, "not issued");
        step;
        chk(pc_out === pc_seen, "pc moved");
        {forced_wr_in, delay_in, divider_tick_in} = {1'b0, 5'h00, 1'b1};
        #1 chk(issue_out === 1'b1 && issue_forced_out === 1'b0 && issue_word_out === 16'h6000, "delay after forced");
        step;
        {forced_wr_in, divider_tick_in, jump_in, jump_target_in} = {1'b1, 1'b0, 1'b1, 5'h11};
        step;
        {forced_wr_in, jump_in} = 2'b00;
        chk(pc_out === 5'h11, "forced jump lost");
    endtask
    // shift-out or move to the latch, then run it from there
    task t_exec(input logic by_out);
        {divider_tick_in, out_exec_in, mov_exec_in, exec_data_in} = {1'b1, by_out, !by_out, 32'hCAFE5A71};
        step;
        {out_exec_in, mov_exec_in} = 2'b00;
        pc_seen = pc_out;
        #1 chk(issue_word_out === 16'h5A71 && issue_forced_out === 1'b0, "latched word");
        chk(out_allowed_out === !by_out, "shift-out gate");
        step;
        chk(pc_out === pc_seen, "pc moved on latch");
    endtask
    // stalled forced word, optionally over a pending latched word
    task t_stall(input logic pending, input logic by_nop);
        {divider_tick_in, out_exec_in, exec_data_in} = {pending, pending, 32'h0000BEEF};
        if (pending)
            step;
        {divider_tick_in, out_exec_in, forced_wr_in, stall_in, forced_wdata_in} = {4'b0011, 16'h2345};
        step;
        {forced_wr_in, divider_tick_in} = 2'b01;
        #1 chk(execute_stalled_flag_out === 1'b1 && issue_word_out === 16'h2345, "stall not held");
        step;
        {divider_tick_in, stall_in, restart_in, forced_wr_in, forced_wdata_in} = {2'b00, !by_nop, by_nop, `SFX_NOP_WORD};
        step;
        {forced_wr_in, restart_in} = 2'b00;
        chk(execute_stalled_flag_out === 1'b0, "flag kept");
    endtask
    initial begin
        {rst_n_in, restart_in, divider_tick_in, forced_wr_in, stall_in, jump_in, wrap_in} = '0;
        {out_exec_in, mov_exec_in, forced_wdata_in, jump_target_in, wrap_target_in, delay_in, exec_data_in} = '0;
        enable_in = 1'b1;
        imem_word_in = 16'h6000;
        repeat (10) @(posedge clk_in);
        #10 rst_n_in = 1'b1;
        step;
        t_forced;
        t_exec(1'b1);
        t_exec(1'b0);
        t_stall(1'b1, 1'b0);
        t_stall(1'b0, 1'b1);
        stop_test;
    end
    initial begin
        repeat (2000) @(posedge clk_in);
        errors++;
        stop_test;
    end
endmodule // testbench
